// ==== hdl/bmps_end.sv ====
// intentionally minimal: no further modules
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ==== hdl/bmps_map.svh ====
// constants of the button mode and program selector
`ifndef BMPS_MAP_SVH
`define BMPS_MAP_SVH
// =====================================================
// timing
`define BMPS_CLK_PERIOD_NS   10
`define BMPS_TICK_NS         1000000
`define BMPS_MODE_HOLD_S     3
`define BMPS_PROG_STEP_S     1
`define BMPS_LAMP_TEST_MS    1000
`define BMPS_DEBOUNCE_MS     20
`define BMPS_BLINK_SLOW_MS   500
`define BMPS_BLINK_FAST_MS   100
// =====================================================
// serial settings
`define BMPS_LEGACY_BAUD     17'h02580
`define BMPS_NORMAL_BAUD     17'h09600
`define BMPS_DATA_BITS       4'h8
`define BMPS_STOP_BITS       2'h1
`define BMPS_PARITY_EN       1'h0
`endif

// ==== hdl/bmps_pkg.sv ====
// types of the button mode and program selector
package bmps_pkg;
  typedef enum logic [1:0] {SYS_LAMPTEST, SYS_READY, SYS_FAULT} bmps_sys_t;
  typedef enum logic [1:0] {PRG_IDLE, PRG_SELECT, PRG_ARMED, PRG_RUN}
    bmps_prog_t;
  typedef enum logic [1:0] {SEL_NONE, SEL_A, SEL_B, SEL_RAM} bmps_sel_t;
endpackage : bmps_pkg

// ==== hdl/bmps_selector.sv ====
// button mode and program selector with lamp driver
// =====================================================
// Overview of operation
// [R1] - mode button held three seconds enters legacy mode, serial lamp flashes fast
// [R2] - legacy mode: only serial port enabled, 9600 baud, 8 bits, no parity
// [R3] - legacy mode refuses program downloads, live control only
// [R4] - short mode press in legacy mode returns to automatic port selection
// [R5] - two flash slots plus a ram slot cleared on supply loss or flash start
// [R6] - held program button steps selection every second: A, B, both, none
// [R7] - a slot lamp lights during selection only if that slot holds a program
// [R8] - after release on a slot, next press starts it; its lamp blinks
// [R9] - press while running stops program, lamp goes steady
// [R10] - ram slot run blinks both lamps, stop makes both steady
// [R11] - stored autostart runs slot A after power-up; press stops it
// [R12] - program button held through lamp test suppresses autostart
// [R13] - supply out of range lights error lamp steady and shuts off
// [R14] - processor fault blinks error lamp, error code on five lamps
// [R15] - power-up lamp test, then usb and serial port lamps blink alternately, ir lamp dark
// [R16] - buttons debounced, hold times counted from a millisecond prescaler
`timescale 1ns/1ps
`default_nettype none
`include "bmps_map.svh"
module bmps_selector #(
  parameter int TICK_CYCLES = `BMPS_TICK_NS / `BMPS_CLK_PERIOD_NS
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // pins, asynchronous
  input  wire logic        modeBtnRaw,
  input  wire logic        progBtnRaw,
  input  wire logic        supplyLowRaw,
  input  wire logic        supplyHighRaw,
  // processor side, same clock
  input  wire logic        cpuFault,
  input  wire logic [4:0]  cpuErrCode,
  input  wire logic        slotAFull,
  input  wire logic        slotBFull,
  input  wire logic        ramFull,
  input  wire logic        autostartStored,
  input  wire logic        downloadReq,
  output logic             downloadAccept,
  // program control
  output logic             progRun,
  output logic [1:0]       progSlot,
  output logic             ramClear,
  // host ports
  output logic             legacyMode,
  output logic             usbPortEn,
  output logic             serialPortEn,
  output logic [16:0]      serialBaud,
  output logic [3:0]       serialDataBits,
  output logic [1:0]       serialStopBits,
  output logic             serialParityEn,
  output logic             shutdown,
  // lamps
  output logic             flash_slot_a_lamp,
  output logic             flash_slot_b_lamp,
  output logic             usbPortLamp,
  output logic             serial_port_lamp,
  output logic             irPortLamp,
  output logic             errorLamp
);
  localparam int TW = $clog2(TICK_CYCLES);
  localparam logic [11:0] MODE_HOLD_MS = 12'(`BMPS_MODE_HOLD_S * 1000);
  localparam logic [11:0] STEP_MS = 12'(`BMPS_PROG_STEP_S * 1000);
  localparam logic [11:0] TEST_MS = 12'(`BMPS_LAMP_TEST_MS);
  localparam logic [11:0] DEB_MS = 12'(`BMPS_DEBOUNCE_MS);
  localparam logic [11:0] SLOW_MS = 12'(`BMPS_BLINK_SLOW_MS);
  localparam logic [11:0] FAST_MS = 12'(`BMPS_BLINK_FAST_MS);

  // =====================================================
  // synchronisers and prescaler
  logic [3:0]    syncA_reg;
  logic [3:0]    syncB_reg;
  logic [TW-1:0] tickCnt_reg;
  logic          msTick;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      syncA_reg <= 4'h0;
      syncB_reg <= 4'h0;
    end else begin
      syncA_reg <= {supplyHighRaw, supplyLowRaw, progBtnRaw, modeBtnRaw};
      syncB_reg <= syncA_reg;
    end
  end
  // one millisecond tick keeps every later counter within twelve bits
  always_ff @(posedge clk) begin
    if (!nrst || tickCnt_reg == TW'(TICK_CYCLES - 1)) begin
      tickCnt_reg <= '0; // [R16]
    end else begin
      tickCnt_reg <= tickCnt_reg + 1'b1;
    end
  end
  assign msTick = (tickCnt_reg == TW'(TICK_CYCLES - 1));

  // =====================================================
  // debounce, bit 0 mode button, bit 1 program button
  wire logic [1:0] btnDb;
  logic [1:0]      btnPrev_reg;
  for (genvar g = 0; g < 2; g++) begin : gDeb
    logic [11:0] cnt_reg;
    logic        stable_reg;
    always_ff @(posedge clk) begin
      if (!nrst) begin
        cnt_reg    <= 12'h000;
        stable_reg <= 1'b0;
      end else if (syncB_reg[g] == stable_reg) begin
        cnt_reg <= 12'h000;
      end else if (msTick) begin
        if (cnt_reg == DEB_MS - 12'h001) begin
          stable_reg <= syncB_reg[g]; // [R16]
          cnt_reg    <= 12'h000;
        end else begin
          cnt_reg <= cnt_reg + 12'h001;
        end
      end
    end
    assign btnDb[g] = stable_reg;
  end
  always_ff @(posedge clk) begin
    if (!nrst) begin
      btnPrev_reg <= 2'h0;
    end else begin
      btnPrev_reg <= btnDb;
    end
  end
  logic modePress, modeRelease, progPress, progRelease;
  assign modePress   = btnDb[0] & ~btnPrev_reg[0];
  assign modeRelease = ~btnDb[0] & btnPrev_reg[0];
  assign progPress   = btnDb[1] & ~btnPrev_reg[1];
  assign progRelease = ~btnDb[1] & btnPrev_reg[1];

  // =====================================================
  // blink phases
  logic [11:0] slowCnt_reg, fastCnt_reg;
  logic        slowPh_reg, fastPh_reg;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      slowCnt_reg <= 12'h000;
      fastCnt_reg <= 12'h000;
      slowPh_reg  <= 1'b0;
      fastPh_reg  <= 1'b0;
    end else if (msTick) begin
      slowCnt_reg <= (slowCnt_reg == SLOW_MS - 12'h001) ? 12'h000
                     : slowCnt_reg + 12'h001;
      fastCnt_reg <= (fastCnt_reg == FAST_MS - 12'h001) ? 12'h000
                     : fastCnt_reg + 12'h001;
      if (slowCnt_reg == SLOW_MS - 12'h001) slowPh_reg <= ~slowPh_reg;
      if (fastCnt_reg == FAST_MS - 12'h001) fastPh_reg <= ~fastPh_reg;
    end
  end

  // =====================================================
  // power-up, supply and fault supervision
  bmps_pkg::bmps_sys_t sys_reg;
  logic [11:0]         testCnt_reg;
  logic [4:0]          errCode_reg;
  logic                shutdown_reg;
  logic                testEnd, ready, supplyBad;
  assign testEnd   = (sys_reg == bmps_pkg::SYS_LAMPTEST) && msTick
                     && (testCnt_reg == TEST_MS - 12'h001);
  assign ready     = (sys_reg == bmps_pkg::SYS_READY);
  assign supplyBad = syncB_reg[2] | syncB_reg[3];
  always_ff @(posedge clk) begin
    if (!nrst) begin
      sys_reg      <= bmps_pkg::SYS_LAMPTEST;
      testCnt_reg  <= 12'h000;
      errCode_reg  <= 5'h00;
      shutdown_reg <= 1'b0;
    end else begin
      shutdown_reg <= supplyBad; // [R13]
      case (sys_reg)
        bmps_pkg::SYS_LAMPTEST: begin
          if (testEnd) sys_reg <= bmps_pkg::SYS_READY; // [R15]
          else if (msTick) testCnt_reg <= testCnt_reg + 12'h001;
        end
        bmps_pkg::SYS_READY: begin
          if (cpuFault) begin
            sys_reg     <= bmps_pkg::SYS_FAULT; // [R14]
            errCode_reg <= cpuErrCode;
          end
        end
        bmps_pkg::SYS_FAULT: sys_reg <= bmps_pkg::SYS_FAULT;
        default: sys_reg <= bmps_pkg::SYS_LAMPTEST;
      endcase
    end
  end

  // =====================================================
  // legacy compatibility mode
  logic        legacy_reg, pressInLegacy_reg;
  logic [11:0] modeMs_reg;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      legacy_reg        <= 1'b0;
      pressInLegacy_reg <= 1'b0;
      modeMs_reg        <= 12'h000;
    end else if (ready) begin
      if (modePress) begin
        modeMs_reg        <= 12'h000;
        pressInLegacy_reg <= legacy_reg;
      end else if (btnDb[0] && msTick && modeMs_reg < MODE_HOLD_MS) begin
        modeMs_reg <= modeMs_reg + 12'h001;
        if (!legacy_reg && modeMs_reg == MODE_HOLD_MS - 12'h001)
          legacy_reg <= 1'b1; // [R1]
      end
      // only a press that began in legacy mode may leave it
      if (modeRelease && legacy_reg && pressInLegacy_reg
          && modeMs_reg < MODE_HOLD_MS)
        legacy_reg <= 1'b0; // [R4]
    end
  end
  assign downloadAccept = downloadReq & ready & ~legacy_reg; // [R3]

  // =====================================================
  // program selection and run control
  bmps_pkg::bmps_prog_t prog_reg;
  bmps_pkg::bmps_sel_t  sel_reg;
  logic [11:0]          progMs_reg;
  logic                 ramClear_reg, selFull;
  always_comb begin
    case (sel_reg)
      bmps_pkg::SEL_A:   selFull = slotAFull;
      bmps_pkg::SEL_B:   selFull = slotBFull;
      bmps_pkg::SEL_RAM: selFull = ramFull;
      default:           selFull = 1'b0;
    endcase
  end
  always_ff @(posedge clk) begin
    if (!nrst) begin
      prog_reg     <= bmps_pkg::PRG_IDLE;
      sel_reg      <= bmps_pkg::SEL_NONE;
      progMs_reg   <= 12'h000;
      ramClear_reg <= 1'b0;
    end else begin
      ramClear_reg <= supplyBad & ~shutdown_reg; // [R5]
      if (testEnd && autostartStored && slotAFull && !btnDb[1]) begin
        prog_reg     <= bmps_pkg::PRG_RUN; // [R11] [R12]
        sel_reg      <= bmps_pkg::SEL_A;
        ramClear_reg <= 1'b1;
      end else if (!ready) begin
        prog_reg <= bmps_pkg::PRG_IDLE; // [R14]
      end else if (shutdown_reg) begin
        if (prog_reg == bmps_pkg::PRG_RUN)
          prog_reg <= bmps_pkg::PRG_ARMED; // [R13]
      end else begin
        case (prog_reg)
          bmps_pkg::PRG_IDLE: begin
            if (progPress) begin
              prog_reg   <= bmps_pkg::PRG_SELECT;
              sel_reg    <= bmps_pkg::SEL_NONE;
              progMs_reg <= 12'h000;
            end
          end
          bmps_pkg::PRG_SELECT: begin
            if (progRelease) begin
              prog_reg <= selFull ? bmps_pkg::PRG_ARMED
                                  : bmps_pkg::PRG_IDLE;
            end else if (msTick) begin
              if (progMs_reg == STEP_MS - 12'h001) begin
                progMs_reg <= 12'h000;
                sel_reg    <= bmps_pkg::bmps_sel_t'(sel_reg + 2'h1); // [R6]
              end else begin
                progMs_reg <= progMs_reg + 12'h001;
              end
            end
          end
          bmps_pkg::PRG_ARMED: begin
            if (progPress) begin
              prog_reg <= bmps_pkg::PRG_RUN; // [R8] [R10]
              if (sel_reg != bmps_pkg::SEL_RAM) ramClear_reg <= 1'b1; // [R5]
            end
          end
          bmps_pkg::PRG_RUN: begin
            if (progPress) prog_reg <= bmps_pkg::PRG_ARMED; // [R9] [R11]
          end
          default: prog_reg <= bmps_pkg::PRG_IDLE;
        endcase
      end
    end
  end
  assign progRun  = (prog_reg == bmps_pkg::PRG_RUN);
  assign progSlot = sel_reg;
  assign ramClear = ramClear_reg;

  // =====================================================
  // registered lamps and port settings
  logic [5:0] lamp_next, lamp_reg;
  logic       showA, showB;
  always_comb begin
    showA = (sel_reg == bmps_pkg::SEL_A && slotAFull)
            || (sel_reg == bmps_pkg::SEL_RAM && ramFull); // [R7]
    showB = (sel_reg == bmps_pkg::SEL_B && slotBFull)
            || (sel_reg == bmps_pkg::SEL_RAM && ramFull);
    if (prog_reg == bmps_pkg::PRG_IDLE) begin
      showA = 1'b0;
      showB = 1'b0;
    end else if (prog_reg == bmps_pkg::PRG_RUN) begin
      showA = showA & slowPh_reg; // [R8] [R10]
      showB = showB & slowPh_reg;
    end
    // order: slot a, slot b, usb, serial, ir, error
    if (sys_reg == bmps_pkg::SYS_LAMPTEST) begin
      lamp_next = 6'h3F; // [R15]
    end else if (sys_reg == bmps_pkg::SYS_FAULT) begin
      lamp_next = {errCode_reg, slowPh_reg}; // [R14]
    end else if (shutdown_reg) begin
      lamp_next = 6'h01; // [R13]
    end else if (legacy_reg) begin
      lamp_next = {showA, showB, 1'b0, fastPh_reg, 2'h0}; // [R1]
    end else begin
      lamp_next = {showA, showB, slowPh_reg, ~slowPh_reg, 2'h0}; // [R15]
    end
  end
  always_ff @(posedge clk) begin
    if (!nrst) begin
      lamp_reg       <= 6'h3F;
      usbPortEn      <= 1'b0;
      serialPortEn   <= 1'b0;
      serialBaud     <= `BMPS_NORMAL_BAUD;
      serialDataBits <= `BMPS_DATA_BITS;
      serialStopBits <= `BMPS_STOP_BITS;
      serialParityEn <= `BMPS_PARITY_EN;
    end else begin
      lamp_reg     <= lamp_next;
      usbPortEn    <= ready & ~shutdown_reg & ~legacy_reg; // [R2]
      serialPortEn <= ready & ~shutdown_reg;
      serialBaud   <= legacy_reg ? `BMPS_LEGACY_BAUD : `BMPS_NORMAL_BAUD;
    end
  end
  assign {flash_slot_a_lamp, flash_slot_b_lamp, usbPortLamp,
          serial_port_lamp, irPortLamp, errorLamp} = lamp_reg;
  assign legacyMode = legacy_reg;
  assign shutdown   = shutdown_reg;

  // =====================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence runPress;
    prog_reg == bmps_pkg::PRG_RUN && progPress && ready && !shutdown_reg;
  endsequence
  sequence armedPress;
    prog_reg == bmps_pkg::PRG_ARMED && progPress && ready && !shutdown_reg
      && !testEnd;
  endsequence
  AST_LEGACY_ENTRY: assert property ($rose(legacy_reg) |-> // [R1]
    $past(btnDb[0]) && $past(modeMs_reg) == MODE_HOLD_MS - 12'h001)
    else $error("legacy mode entered without a full hold");
  AST_LEGACY_PORTS: assert property (legacy_reg && ready && !shutdown_reg // [R2]
    |=> !usbPortEn && serialPortEn && serialBaud == `BMPS_LEGACY_BAUD)
    else $error("legacy port settings wrong");
  AST_NO_DOWNLOAD: assert property (legacy_reg |-> !downloadAccept) // [R3]
    else $error("download accepted in legacy mode");
  AST_LEGACY_EXIT: assert property ($fell(legacy_reg) |-> $past(modeRelease)) // [R4]
    else $error("legacy mode left without a short press");
  AST_RAM_CLEAR: assert property (armedPress ##0 // [R5]
    (sel_reg != bmps_pkg::SEL_RAM) |=> ramClear && progRun)
    else $error("flash start did not clear ram slot");
  AST_EMPTY_DARK: assert property (ready && !shutdown_reg // [R7]
    && prog_reg == bmps_pkg::PRG_SELECT && !slotAFull && !ramFull
    |=> !flash_slot_a_lamp)
    else $error("lamp shown for empty slot");
  AST_STOP: assert property (runPress ##0 // [R9]
    (sel_reg == bmps_pkg::SEL_A && slotAFull)
    |=> prog_reg == bmps_pkg::PRG_ARMED ##1 flash_slot_a_lamp)
    else $error("press did not stop program");
  AST_SUPPRESS: assert property (testEnd && btnDb[1] |=> !progRun) // [R12]
    else $error("autostart not suppressed");
  AST_SUPPLY: assert property (supplyBad && ready // [R13]
    |=> shutdown ##1 errorLamp && !serialPortEn)
    else $error("supply fault not shown");
  AST_LAMP_TEST: assert property (sys_reg == bmps_pkg::SYS_LAMPTEST // [R15]
    |=> lamp_reg == 6'h3F)
    else $error("lamp test not lighting all lamps");
endmodule : bmps_selector
`default_nettype wire

// ==== sim/bmps_operator.sv ====
// operator model pressing the two push buttons
`timescale 1ns/1ps
`default_nettype none
// ====================================================
// operator at the buttons
module bmps_operator (
  // clock
  input  wire logic clk,
  // buttons, high = pressed
  output logic      modeBtnRaw,
  output logic      progBtnRaw
);
  initial begin
    modeBtnRaw = 1'b0;
    progBtnRaw = 1'b0;
  end
  // contacts bounce on every change; a real finger is no cleaner
  task automatic drive(input bit prog, input logic lvl);
    logic v;
    for (int i = 0; i < 7; i++) begin
      @(negedge clk);
      v = lvl ^ ((i % 2 == 1) && (i < 6));
      if (prog) progBtnRaw = v;
      else modeBtnRaw = v;
    end
  endtask : drive
  task automatic hold(input bit prog, input int n);
    drive(prog, 1'b1);
    repeat (n) @(negedge clk);
    drive(prog, 1'b0);
  endtask : hold
  // short press: past the debounce time, far below one second
  task automatic press(input bit prog);
    hold(prog, 200);
    repeat (100) @(negedge clk);
  endtask : press
endmodule : bmps_operator
`default_nettype wire

// ==== sim/button_mode_program_selector_tb_top.sv ====
// testbench of the button mode and program selector
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin \
  err_total++; $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
`define WAITFOR(c, n) begin for (int k = 0; k < n && !(c); k++) \
  @(negedge clk); if (!(c)) begin err_total++; test_done(); end end
module button_mode_program_selector_tb_top;
  // ====================================================
  // signals
  logic        clk, nrst, supplyLowRaw, supplyHighRaw, cpuFault;
  logic [4:0]  cpuErrCode;
  logic        slotAFull, slotBFull, ramFull, autostartStored;
  logic        downloadReq, downloadAccept, progRun, ramClear;
  logic        legacyMode, usbPortEn, serialPortEn, shutdown;
  logic [1:0]  progSlot, serialStopBits;
  logic [16:0] serialBaud;
  logic [3:0]  serialDataBits;
  logic        serialParityEn, flash_slot_a_lamp, flash_slot_b_lamp;
  logic        usbPortLamp, serial_port_lamp, irPortLamp, errorLamp;
  wire         modeBtnRaw, progBtnRaw;
  logic [7:0]  seen;
  int          err_total = 0, comparisons = 0, clrCount = 0, c0, tog;
  // ====================================================
  // clock, design and operator
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // 2 clocks a millisecond keeps every second-long step short
  bmps_selector #(.TICK_CYCLES(2)) DUT (.clk, .nrst, .modeBtnRaw,
    .progBtnRaw, .supplyLowRaw, .supplyHighRaw, .cpuFault, .cpuErrCode,
    .slotAFull, .slotBFull, .ramFull, .autostartStored, .downloadReq,
    .downloadAccept, .progRun, .progSlot, .ramClear, .legacyMode,
    .usbPortEn, .serialPortEn, .serialBaud, .serialDataBits,
    .serialStopBits, .serialParityEn, .shutdown, .flash_slot_a_lamp,
    .flash_slot_b_lamp, .usbPortLamp, .serial_port_lamp, .irPortLamp,
    .errorLamp);
  bmps_operator op (.clk, .modeBtnRaw, .progBtnRaw);
  // counted off the falling edge so the pulse is settled
  always @(negedge clk) if (ramClear === 1'b1) clrCount++;
  // ====================================================
  // shared tasks
  task automatic test_done();
    if (err_total == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : test_done
  task automatic rst_dut();
    @(negedge clk);
    nrst = 1'b0;
    repeat (20) @(negedge clk);
    nrst = 1'b1;
  endtask : rst_dut
  // records which lamp levels showed up, and serial lamp toggles
  task automatic observe(input int n);
    logic last;
    seen = 8'h00;
    tog = 0;
    last = serial_port_lamp;
    repeat (n) begin
      @(negedge clk);
      seen |= {usbPortLamp === serial_port_lamp, usbPortLamp === 1'b1,
        errorLamp === 1'b0, errorLamp === 1'b1,
        flash_slot_b_lamp === 1'b0, flash_slot_b_lamp === 1'b1,
        flash_slot_a_lamp === 1'b0, flash_slot_a_lamp === 1'b1};
      if (serial_port_lamp !== last) tog++;
      last = serial_port_lamp;
    end
  endtask : observe
  // ====================================================
  // scenarios
  task automatic t_suppress();
    fork
      op.drive(1'b1, 1'b1);
      rst_dut();
    join
    repeat (1000) @(negedge clk);
    `CHK("lamp test", 6'h3F, {flash_slot_a_lamp, flash_slot_b_lamp,
      usbPortLamp, serial_port_lamp, irPortLamp, errorLamp})
    repeat (1200) @(negedge clk);
    `CHK("suppressed", 1'b0, progRun)
    op.drive(1'b1, 1'b0);
    observe(1200);
    `CHK("port lamps alternate", 2'b01, seen[7:6])
    `CHK("ir lamp", 1'b0, irPortLamp)
  endtask : t_suppress
  // only slot b holds a program: a stays dark, b lights at its step
  task automatic t_empty();
    {slotAFull, slotBFull, ramFull} = 3'b010;
    op.drive(1'b1, 1'b1);
    observe(7000);
    `CHK("empty slots dark", 2'b01, {seen[0], seen[2]})
    op.drive(1'b1, 1'b0);
    repeat (100) @(negedge clk);
    `CHK("empty release idle", 3'b000,
      {progRun, flash_slot_a_lamp, flash_slot_b_lamp})
    {slotAFull, slotBFull, ramFull} = 3'b101;
  endtask : t_empty
  task automatic t_autostart();
    c0 = clrCount;
    rst_dut();
    repeat (2200) @(negedge clk);
    `CHK("autostart", 3'b101, {progRun, progSlot})
    `CHK("autostart ram clear", 1, clrCount - c0)
    observe(1200);
    `CHK("autostart blink", 2'b11, seen[1:0])
    op.press(1'b1);
    `CHK("autostart stop", 1'b0, progRun)
  endtask : t_autostart
  task automatic t_ram();
    autostartStored = 1'b0;
    rst_dut();
    repeat (2200) @(negedge clk);
    op.drive(1'b1, 1'b1);
    `WAITFOR(flash_slot_a_lamp === 1'b1, 2400)
    repeat (3000) @(negedge clk);
    `CHK("empty slot dark", 2'b00,
      {flash_slot_a_lamp, flash_slot_b_lamp})
    repeat (2000) @(negedge clk);
    `CHK("ram selected", 2'b11,
      {flash_slot_a_lamp, flash_slot_b_lamp})
    op.drive(1'b1, 1'b0);
    repeat (100) @(negedge clk);
    c0 = clrCount;
    op.press(1'b1);
    `CHK("ram run", 3'b111, {progRun, progSlot})
    `CHK("ram kept", 0, clrCount - c0)
    observe(1200);
    `CHK("ram blink", 4'hF, seen[3:0])
    op.press(1'b1);
    observe(1200);
    `CHK("ram stop steady", 5'h05, {progRun, seen[3:0]})
  endtask : t_ram
  task automatic t_slot_a();
    rst_dut();
    repeat (2200) @(negedge clk);
    op.drive(1'b1, 1'b1);
    `WAITFOR(flash_slot_a_lamp === 1'b1, 2400)
    repeat (500) @(negedge clk);
    op.drive(1'b1, 1'b0);
    repeat (100) @(negedge clk);
    c0 = clrCount;
    op.press(1'b1);
    `CHK("slot a run", 3'b101, {progRun, progSlot})
    `CHK("flash start clears ram", 1, clrCount - c0)
    observe(1200);
    `CHK("slot a blink", 4'hB, seen[3:0])
    op.press(1'b1);
    observe(1200);
    `CHK("slot a stop steady", 3'b001, {progRun, seen[1:0]})
  endtask : t_slot_a
  task automatic t_legacy();
    downloadReq = 1'b1;
    @(negedge clk);
    `CHK("download normal", 1'b1, downloadAccept)
    op.drive(1'b0, 1'b1);
    repeat (6200) @(negedge clk);
    `CHK("legacy ports", 3'b101,
      {legacyMode, usbPortEn, serialPortEn})
    `CHK("legacy baud", 17'h02580, serialBaud)
    `CHK("legacy frame", 7'h42,
      {serialDataBits, serialStopBits, serialParityEn})
    `CHK("legacy download", 1'b0, downloadAccept)
    observe(1000);
    `CHK("fast flash", 1'b1, tog > 3)
    op.drive(1'b0, 1'b0);
    repeat (100) @(negedge clk);
    `CHK("legacy kept", 1'b1, legacyMode)
    op.press(1'b0);
    `CHK("legacy left", 3'b011,
      {legacyMode, usbPortEn, downloadAccept})
    downloadReq = 1'b0;
  endtask : t_legacy
  task automatic t_supply();
    for (int s = 0; s < 2; s++) begin
      c0 = clrCount;
      {supplyHighRaw, supplyLowRaw} = 2'b01 << s;
      repeat (10) @(negedge clk);
      `CHK("shut off", 4'hC,
        {shutdown, errorLamp, usbPortEn, serialPortEn})
      `CHK("supply ram clear", 1, clrCount - c0)
      observe(1200);
      `CHK("error steady", 2'b01, seen[5:4])
      {supplyHighRaw, supplyLowRaw} = 2'b00;
      repeat (10) @(negedge clk);
      `CHK("supply back", 1'b0, shutdown)
    end
  endtask : t_supply
  task automatic t_fault();
    cpuErrCode = 5'h15;
    cpuFault = 1'b1;
    repeat (10) @(negedge clk);
    `CHK("error code", 5'h15, {flash_slot_a_lamp, flash_slot_b_lamp,
      usbPortLamp, serial_port_lamp, irPortLamp})
    observe(1200);
    `CHK("error blink", 2'b11, seen[5:4])
  endtask : t_fault
  // ====================================================
  // main sequence
  initial begin
    nrst = 1'b0;
    {supplyLowRaw, supplyHighRaw, cpuFault, downloadReq} = 4'h0;
    cpuErrCode = 5'h00;
    {slotAFull, slotBFull, ramFull, autostartStored} = 4'hB;
    t_suppress();
    t_empty();
    t_autostart();
    t_ram();
    t_slot_a();
    t_legacy();
    t_supply();
    t_fault();
    test_done();
  end
endmodule : button_mode_program_selector_tb_top
`default_nettype wire
